// ---- core/serial_link_power_startup.sv ----
`timescale 1ns/1ns

// What this block does
// - Writing sleep bit one sleeps at once; protection reset, config kept.
// - Display application select with autostart disabled powers up asleep.
// - Power-down input low enters power-down.
// - Serial output is undriven during power-down.
// - Power-down returns control and reverse registers to reset value; straps register keeps its value.
// - Leaving power-down latches config, reverse-mode and bus-width straps.
// - Without pixel clock, configuration link runs from internal oscillator.
// - Config-link enable activates config link until video link enabled.
// - Serial-output enable overrides config link and attempts lock.
// - Reverse mode: legacy, robust 500 kbps, or fast 1000 kbps.
// - Changing robust bit makes reverse channel unavailable for 500 us.
// - Control channel carries traffic only once a link is established.
// - Late remote power-up blocks the control channel for 2 ms.
// - Without autostart, no link starts until host enables one.
module serial_link_power_startup #(
    parameter int unsigned WAKE_CYCLES = link_power_pkg::WAKE_CYCLES,
    parameter int unsigned REMOTE_CYCLES = link_power_pkg::REMOTE_CYCLES,
    parameter int unsigned REVERSE_CYCLES = link_power_pkg::REVERSE_CYCLES
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Pins
    input wire logic power_down_n,
    input wire logic application_select,
    input wire logic [3:0] config_straps,
    input wire logic reverse_mode_strap,
    input wire logic [1:0] bus_width_select,
    input wire logic pixel_clock_in,
    input wire logic remote_power_up,
    input wire logic ctrl_command_seen,
    // Link state
    output logic serial_out_oe,
    output logic asleep,
    output logic protect_reset,
    output logic video_link_active,
    output logic cfg_link_active,
    output logic osc_enable,
    output logic ctrl_channel_ready,
    output logic reverse_channel_ready,
    output link_power_pkg::rev_mode_e reverse_mode
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [11:0] pins_raw;
    logic [11:0] sync1_r;
    logic [11:0] sync2_r;
    logic pclk_prev_r;
    logic remote_prev_r;
    logic cmd_prev_r;

    assign pins_raw = {pixel_clock_in, remote_power_up, ctrl_command_seen,
                       power_down_n, application_select, reverse_mode_strap,
                       bus_width_select, config_straps};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_r <= 12'h000;
            sync2_r <= 12'h000;
            pclk_prev_r <= 1'b0;
            remote_prev_r <= 1'b0;
            cmd_prev_r <= 1'b0;
        end
        else
        begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
            pclk_prev_r <= sync2_r[11];
            remote_prev_r <= sync2_r[10];
            cmd_prev_r <= sync2_r[9];
        end
    end

    wire pclk_toggle = sync2_r[11] ^ pclk_prev_r;
    wire remote_rise = sync2_r[10] & ~remote_prev_r;
    wire cmd_rise = sync2_r[9] & ~cmd_prev_r;
    wire pd_active = ~sync2_r[8];
    link_power_pkg::straps_s straps_now;
    assign straps_now = sync2_r[7:0];

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [31:0] addr,
                                 input logic [7:0] idx);
        hit = (addr[31:2] == {22'h000000, idx}) && (addr[1:0] == 2'b00);
    endfunction

    logic wr_pend_r;
    logic rd_pend_r;
    logic [31:0] addr_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;

    wire accept = hsel & htrans[1] & hready & hreadyout_r;
    wire wr_ctrl = wr_pend_r & hit(addr_r, link_power_pkg::IDX_CTRL);
    wire wr_rev = wr_pend_r & hit(addr_r, link_power_pkg::IDX_REVERSE);

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    logic up_r;
    link_power_pkg::straps_s straps_r;
    link_power_pkg::ctrl_s ctrl_r;
    link_power_pkg::ctrl_s ctrl_nxt;
    link_power_pkg::ctrl_s wr_val;
    logic fast_r;
    logic asleep_r;
    logic protect_reset_r;
    logic [19:0] wake_cnt_r;
    logic [19:0] remote_cnt_r;
    logic [19:0] rev_cnt_r;
    logic [5:0] pclk_cnt_r;

    assign wr_val = hwdata[4:0];
    assign ctrl_nxt = wr_ctrl ? wr_val : ctrl_r;

    // Latched strap defaults: conf0 high selects low rate, conf3 high
    // disables autostart.
    wire no_autostart = straps_now.conf[3];
    wire latch_now = ~pd_active & ~up_r;
    link_power_pkg::ctrl_s strap_ctrl;
    assign strap_ctrl = '{rate: straps_now.conf[0],
                          robust: straps_now.rev_strap,
                          cfg_en: 1'b0,
                          serial_output_enable: ~no_autostart,
                          sleep: 1'b0};
    wire boot_asleep = straps_now.app_sel & no_autostart;

    wire sleep_set = wr_ctrl & wr_val.sleep & up_r;
    wire wake_start = asleep_r & cmd_rise & (wake_cnt_r == 20'h00000);
    wire wake_done = asleep_r & (wake_cnt_r == 20'h00001);
    wire rev_change = wr_ctrl & (wr_val.robust != ctrl_r.robust);
    wire pclk_present = pclk_cnt_r != 6'h00;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            up_r <= 1'b0;
            straps_r <= '0;
            ctrl_r <= '0;
            fast_r <= 1'b0;
            asleep_r <= 1'b0;
            protect_reset_r <= 1'b0;
        end
        else if (pd_active)
        begin
            up_r <= 1'b0;
            ctrl_r <= '0;
            fast_r <= 1'b0;
            asleep_r <= 1'b0;
            protect_reset_r <= 1'b0;
        end
        else if (latch_now)
        begin
            up_r <= 1'b1;
            straps_r <= straps_now;
            ctrl_r <= strap_ctrl;
            asleep_r <= boot_asleep;
            protect_reset_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            if (wr_rev)
                fast_r <= hwdata[link_power_pkg::REVERSE_FAST];
            if (sleep_set)
                asleep_r <= 1'b1;
            else if (wake_done)
                asleep_r <= 1'b0;
            protect_reset_r <= sleep_set & ~asleep_r;
        end
    end

    // ------------------------------------------------------------------
    // Hold-off counters
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wake_cnt_r <= 20'h00000;
            remote_cnt_r <= 20'h00000;
            rev_cnt_r <= 20'h00000;
            pclk_cnt_r <= 6'h00;
        end
        else if (pd_active)
        begin
            wake_cnt_r <= 20'h00000;
            remote_cnt_r <= 20'h00000;
            rev_cnt_r <= 20'h00000;
            pclk_cnt_r <= 6'h00;
        end
        else
        begin
            if (wake_start)
                wake_cnt_r <= 20'(WAKE_CYCLES);
            else if (wake_cnt_r != 20'h00000)
                wake_cnt_r <= wake_cnt_r - 20'h00001;
            if (remote_rise & up_r)
                remote_cnt_r <= 20'(REMOTE_CYCLES);
            else if (remote_cnt_r != 20'h00000)
                remote_cnt_r <= remote_cnt_r - 20'h00001;
            if (rev_change & up_r)
                rev_cnt_r <= 20'(REVERSE_CYCLES);
            else if (rev_cnt_r != 20'h00000)
                rev_cnt_r <= rev_cnt_r - 20'h00001;
            if (pclk_toggle)
                pclk_cnt_r <= link_power_pkg::PCLK_WINDOW;
            else if (pclk_present)
                pclk_cnt_r <= pclk_cnt_r - 6'h01;
        end
    end

    // ------------------------------------------------------------------
    // Link control outputs
    // ------------------------------------------------------------------
    wire awake = up_r & ~asleep_r;
    wire video_nxt = awake & ctrl_r.serial_output_enable & pclk_present;
    wire cfg_nxt = awake & ctrl_r.cfg_en & ~ctrl_r.serial_output_enable;
    // Readiness follows the next link state, so it drops with the link.
    wire ctrl_nxt_ok = (video_nxt | cfg_nxt)
                       & (remote_cnt_r == 20'h00000);
    link_power_pkg::rev_mode_e mode_nxt;
    assign mode_nxt = !ctrl_r.robust ? link_power_pkg::REV_LEGACY
                    : fast_r ? link_power_pkg::REV_FAST
                    : link_power_pkg::REV_ROBUST;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            serial_out_oe <= 1'b0;
            video_link_active <= 1'b0;
            cfg_link_active <= 1'b0;
            osc_enable <= 1'b0;
            ctrl_channel_ready <= 1'b0;
            reverse_channel_ready <= 1'b0;
            reverse_mode <= link_power_pkg::REV_LEGACY;
        end
        else
        begin
            serial_out_oe <= ~pd_active & awake & ctrl_r.serial_output_enable;
            video_link_active <= ~pd_active & video_nxt;
            cfg_link_active <= ~pd_active & cfg_nxt;
            osc_enable <= ~pd_active & cfg_nxt;
            ctrl_channel_ready <= ~pd_active & ctrl_nxt_ok;
            reverse_channel_ready <= ~pd_active & ctrl_nxt_ok
                                     & (rev_cnt_r == 20'h00000);
            reverse_mode <= mode_nxt;
        end
    end

    assign asleep = asleep_r;
    assign protect_reset = protect_reset_r;

    // ------------------------------------------------------------------
    // AHB-Lite slave: writes take no wait, reads take one wait state
    // ------------------------------------------------------------------
    wire [31:0] status_word = {24'h000000, reverse_mode,
                               reverse_channel_ready, ctrl_channel_ready,
                               cfg_link_active, video_link_active,
                               pclk_present, asleep_r};
    wire [31:0] rd_mux =
        hit(addr_r, link_power_pkg::IDX_CTRL) ? {27'h0000000, ctrl_r}
      : hit(addr_r, link_power_pkg::IDX_STATUS) ? status_word
      : hit(addr_r, link_power_pkg::IDX_STRAPS) ? {24'h000000, straps_r}
      : hit(addr_r, link_power_pkg::IDX_REVERSE) ? {24'h000000, fast_r,
                                                    7'h00}
      : link_power_pkg::RESET_DATA;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= 32'h0000_0000;
            hrdata_r <= 32'h0000_0000;
            hreadyout_r <= 1'b1;
        end
        else
        begin
            wr_pend_r <= accept & hwrite;
            rd_pend_r <= accept & ~hwrite;
            if (accept)
                addr_r <= haddr;
            hreadyout_r <= ~(accept & ~hwrite);
            if (rd_pend_r)
                hrdata_r <= rd_mux;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = 1'b0;

endmodule

// ---- common/link_power_pkg.sv ----
package link_power_pkg;

    // ------------------------------------------------------------------
    // Register map: word index, byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL = 8'h00;
    localparam logic [7:0] IDX_STATUS = 8'h01;
    localparam logic [7:0] IDX_STRAPS = 8'h02;
    localparam logic [7:0] IDX_REVERSE = 8'h1A;

    localparam int CTRL_SLEEP = 0;
    localparam int CTRL_SERIAL_OUTPUT_ENABLE = 1;
    localparam int CTRL_CFGEN = 2;
    localparam int CTRL_ROBUST = 3;
    localparam int CTRL_RATE = 4;
    localparam int REVERSE_FAST = 7;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int WAKE_TIME_US = 5000;
    localparam int REMOTE_HOLD_US = 2000;
    localparam int REVERSE_HOLD_US = 500;
    localparam int WAKE_CYCLES = WAKE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int REMOTE_CYCLES = REMOTE_HOLD_US * 1000 / CLK_PERIOD_NS;
    localparam int REVERSE_CYCLES = REVERSE_HOLD_US * 1000 / CLK_PERIOD_NS;
    localparam logic [5:0] PCLK_WINDOW = 6'h20;

    localparam logic [31:0] RESET_DATA = 32'h0000_0000;

    typedef enum logic [1:0] {
        REV_LEGACY = 2'b00,
        REV_ROBUST = 2'b01,
        REV_FAST = 2'b10
    } rev_mode_e;

    typedef struct packed {
        logic rate;
        logic robust;
        logic cfg_en;
        logic serial_output_enable;
        logic sleep;
    } ctrl_s;

    typedef struct packed {
        logic app_sel;
        logic rev_strap;
        logic [1:0] width_sel;
        logic [3:0] conf;
    } straps_s;

endpackage

// ---- tb/serial_link_power_startup_properties.sv ----
`timescale 1ns/1ns
module link_power_properties (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    // Pins
    input wire logic power_down_n,
    input wire logic remote_power_up,
    // Link state
    input wire logic serial_out_oe,
    input wire logic asleep,
    input wire logic protect_reset,
    input wire logic video_link_active,
    input wire logic cfg_link_active,
    input wire logic osc_enable,
    input wire logic ctrl_channel_ready
);
    logic wr_ctrl_r;

    // ------------------------------------------------------------------
    // Write tracking
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wr_ctrl_r <= 1'h0;
        else if (hready)
            wr_ctrl_r <= hsel && htrans[1] && hwrite && (haddr == 32'h0);
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_sleep_at_once: assert property (
        wr_ctrl_r && hready && hwdata[0] && power_down_n |=> asleep)
        else $error("sleep write did not sleep");
    a_pulse_short: assert property (
        protect_reset |=> !protect_reset)
        else $error("protect reset longer than one cycle");
    a_sleep_undriven: assert property (
        asleep [*2] |-> !serial_out_oe)
        else $error("serial output driven while asleep");
    a_down_hiz: assert property (
        !power_down_n [*4] |=> !serial_out_oe)
        else $error("serial output driven in power-down");
    a_down_reset: assert property (
        !power_down_n [*4] |=> !video_link_active && !cfg_link_active)
        else $error("link active in power-down");
    a_osc_cfg: assert property (
        cfg_link_active |-> osc_enable)
        else $error("config link without oscillator");
    a_video_wins: assert property (
        cfg_link_active |-> !video_link_active)
        else $error("config and video link both active");
    a_ctrl_link: assert property (
        ctrl_channel_ready |-> video_link_active || cfg_link_active)
        else $error("control channel ready without link");
    a_remote_hold: assert property (
        $rose(remote_power_up) && ctrl_channel_ready
        |-> ##[1:5] !ctrl_channel_ready)
        else $error("control channel not held after remote power-up");

    c_sleep: cover property (protect_reset);
    c_cfg: cover property (cfg_link_active);
    c_video: cover property ($rose(video_link_active));
endmodule

bind serial_link_power_startup link_power_properties chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .power_down_n(power_down_n), .remote_power_up(remote_power_up),
    .serial_out_oe(serial_out_oe), .asleep(asleep),
    .protect_reset(protect_reset), .video_link_active(video_link_active),
    .cfg_link_active(cfg_link_active), .osc_enable(osc_enable),
    .ctrl_channel_ready(ctrl_channel_ready)
);

// ---- tb/remote_link_model.sv ----
`timescale 1ns/1ns
module remote_link_model (
    // Clock
    input wire logic hclk,
    // Requests from the bench
    input wire logic pclk_on,
    input wire logic remote_on,
    input wire logic cmd_req,
    // Pins toward the block
    output logic pixel_clock_in,
    output logic remote_power_up,
    output logic ctrl_command_seen
);
    // The pixel clock stops low when video is not offered.
    always @(posedge hclk)
    begin
        pixel_clock_in <= pclk_on ? !pixel_clock_in : 1'h0;
        remote_power_up <= remote_on;
        ctrl_command_seen <= cmd_req;
    end
endmodule

// ---- tb/serial_link_power_startup_test.sv ----
`timescale 1ns/1ns
module serial_link_power_startup_test;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
    logic [1:0] htrans = 2'h0, bus_width_select = 2'h1;
    logic [2:0] hsize = 3'h2;
    logic [3:0] config_straps = 4'h8;
    logic power_down_n = 1'h1, application_select = 1'h0;
    logic reverse_mode_strap = 1'h0, pclk_on = 1'h0;
    logic remote_on = 1'h0, cmd_req = 1'h0, hready, hreadyout, hresp;
    logic pixel_clock_in, remote_power_up, ctrl_command_seen;
    logic serial_out_oe, asleep, protect_reset, video_link_active;
    logic cfg_link_active, osc_enable, ctrl_channel_ready;
    logic reverse_channel_ready;
    link_power_pkg::rev_mode_e reverse_mode;
    int bad_count = 0, tests_run = 0, cycles = 0, pr_seen = 0;

    assign hready = hreadyout;

    serial_link_power_startup #(.WAKE_CYCLES(50), .REMOTE_CYCLES(40),
        .REVERSE_CYCLES(30)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .power_down_n(power_down_n),
        .application_select(application_select),
        .config_straps(config_straps),
        .reverse_mode_strap(reverse_mode_strap),
        .bus_width_select(bus_width_select),
        .pixel_clock_in(pixel_clock_in), .remote_power_up(remote_power_up),
        .ctrl_command_seen(ctrl_command_seen),
        .serial_out_oe(serial_out_oe), .asleep(asleep),
        .protect_reset(protect_reset), .video_link_active(video_link_active),
        .cfg_link_active(cfg_link_active), .osc_enable(osc_enable),
        .ctrl_channel_ready(ctrl_channel_ready),
        .reverse_channel_ready(reverse_channel_ready),
        .reverse_mode(reverse_mode));

    remote_link_model far (.hclk(hclk), .pclk_on(pclk_on),
        .remote_on(remote_on), .cmd_req(cmd_req),
        .pixel_clock_in(pixel_clock_in), .remote_power_up(remote_power_up),
        .ctrl_command_seen(ctrl_command_seen));

    // ------------------------------------------------------------------
    // Clock, timeout and pulse monitor
    // ------------------------------------------------------------------
    initial
    begin
        forever #5 hclk = ~hclk;
    end

    always @(posedge hclk)
    begin
        cycles++;
        if (protect_reset === 1'h1)
            pr_seen++;
        if (cycles == 3000)
        begin
            bad_count++;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    task automatic bus(input logic [7:0] idx, input logic wr,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'h0};
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        d = hrdata;
        hsel <= 1'h0;
        #1;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_start();
        bus(link_power_pkg::IDX_STRAPS, 1'h0, 32'h0);
        chk("straps", 32'h18, d);
        chk("okay resp", 32'h0, hresp);
        chk("video idle", 32'h0, video_link_active);
        chk("cfg idle", 32'h0, cfg_link_active);
    endtask

    task automatic t_links();
        bus(link_power_pkg::IDX_CTRL, 1'h1, 32'h04);
        tick(3);
        chk("cfg link", 32'h1, cfg_link_active);
        chk("oscillator", 32'h1, osc_enable);
        pclk_on <= 1'h1;
        bus(link_power_pkg::IDX_CTRL, 1'h1, 32'h06);
        tick(40);
        chk("video link", 32'h1, video_link_active);
        chk("cfg yields", 32'h0, cfg_link_active);
        chk("output on", 32'h1, serial_out_oe);
        bus(link_power_pkg::IDX_STATUS, 1'h0, 32'h0);
        chk("status", 32'h36, d);
    endtask

    task automatic t_sleep();
        pr_seen = 0;
        bus(link_power_pkg::IDX_CTRL, 1'h1, 32'h07);
        tick(3);
        chk("asleep", 32'h1, asleep);
        chk("output off", 32'h0, serial_out_oe);
        chk("protect pulse", 32'h1, pr_seen);
        bus(link_power_pkg::IDX_CTRL, 1'h0, 32'h0);
        chk("config kept", 32'h07, d);
        cmd_req <= 1'h1;
        tick(1);
        cmd_req <= 1'h0;
        tick(40);
        chk("still asleep", 32'h1, asleep);
        tick(30);
        chk("woken", 32'h0, asleep);
        bus(link_power_pkg::IDX_CTRL, 1'h1, 32'h06);
        tick(40);
        chk("video back", 32'h1, video_link_active);
    endtask

    task automatic t_reverse();
        bus(link_power_pkg::IDX_CTRL, 1'h1, 32'h0E);
        tick(3);
        chk("robust", link_power_pkg::REV_ROBUST, reverse_mode);
        tick(20);
        chk("rev held", 32'h0, reverse_channel_ready);
        tick(15);
        chk("rev back", 32'h1, reverse_channel_ready);
        bus(link_power_pkg::IDX_REVERSE, 1'h1, 32'h80);
        tick(2);
        chk("fast", link_power_pkg::REV_FAST, reverse_mode);
        bus(link_power_pkg::IDX_CTRL, 1'h1, 32'h06);
        tick(2);
        chk("legacy", link_power_pkg::REV_LEGACY, reverse_mode);
    endtask

    task automatic t_remote();
        remote_on <= 1'h1;
        tick(6);
        chk("ctrl held", 32'h0, ctrl_channel_ready);
        tick(45);
        chk("ctrl back", 32'h1, ctrl_channel_ready);
    endtask

    task automatic t_power_down();
        config_straps <= 4'h9;
        bus_width_select <= 2'h2;
        reverse_mode_strap <= 1'h1;
        power_down_n <= 1'h0;
        tick(6);
        chk("pd output", 32'h0, serial_out_oe);
        chk("pd video", 32'h0, video_link_active);
        power_down_n <= 1'h1;
        tick(6);
        bus(link_power_pkg::IDX_CTRL, 1'h0, 32'h0);
        chk("ctrl reset", 32'h18, d);
        bus(link_power_pkg::IDX_STRAPS, 1'h0, 32'h0);
        chk("straps new", 32'h69, d);
        chk("not asleep", 32'h0, asleep);
        chk("strap mode", link_power_pkg::REV_ROBUST, reverse_mode);
    endtask

    initial
    begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'h1;
        tick(5);
        t_start();
        t_links();
        t_sleep();
        t_reverse();
        t_remote();
        t_power_down();
        close_out();
    end
endmodule
